// [design/i2cmx_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "i2cmx_cfg.svh"
module i2cmx_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic irq,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe
);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction : hit

  // bus slave state
  logic [7:0] ad_r;
  logic wr_r;
  logic rd_r;
  logic hreadyout_r;
  logic [31:0] hrdata_r;
  // software registers
  logic [3:0] ctrl_r;
  logic [15:0] div_r;
  logic [6:0] own_r;
  logic [6:0] tgt_r;
  logic [`I2CMX_NEV-1:0] mask_r;
  logic start_req_r;
  logic stop_req_r;
  logic [7:0] transmit_buffer_r;
  logic txfull_r;
  logic [7:0] rxbuf_r;
  // bus monitor
  logic scl_q;
  logic sda_q;
  logic busy_r;
  logic clk_low_r;
  // master engine
  i2cmx_pkg::i2cmx_state_e st_r;
  logic [1:0] ph_r;
  logic [3:0] cnt_r;
  logic [7:0] sh_r;
  logic adr_r;
  logic m_rd_r;
  logic nk_r;
  logic m_scl_dn_r;
  logic m_sda_dn_r;
  logic [3:0] ev_r;
  // slave receiver
  logic sl_on_r;
  logic sl_adr_r;
  logic [3:0] sl_cnt_r;
  logic [7:0] sl_sh_r;
  logic sl_ack_r;
  logic sl_load_r;
  // pins
  logic scl_oe_r;
  logic sda_oe_r;
  logic drv_lvl_r;
  logic tick;
  logic irq_w;
  logic [`I2CMX_NEV-1:0] flags_w;

  // bus decode; only whole-word singles are issued, so hsize is not decoded
  wire logic addr_ph = hsel && hready && htrans[1];
  wire logic wr_ctrl = wr_r && hit(ad_r, `I2CMX_OFF_CTRL);
  wire logic wr_transmit_buffer = wr_r && hit(ad_r, `I2CMX_OFF_TRANSMIT_BUFFER);
  wire logic wr_ifg = wr_r && hit(ad_r, `I2CMX_OFF_IFG);
  wire logic rd_rxbuf = rd_r && hit(ad_r, `I2CMX_OFF_RXBUF);
  wire logic wr_stt = wr_ctrl && hwdata[`I2CMX_B_STT];
  wire logic en_w = ctrl_r[`I2CMX_B_EN];
  wire logic mst_w = ctrl_r[`I2CMX_B_MST];
  wire logic mm_w = ctrl_r[`I2CMX_B_MM];
  wire logic tr_w = ctrl_r[`I2CMX_B_TR];

  // bus line events, pins already synchronous to hclk
  wire logic start_det = scl_i && scl_q && sda_q && !sda_i;
  wire logic stop_det = scl_i && scl_q && !sda_q && sda_i;
  wire logic scl_fall = scl_q && !scl_i;
  wire logic scl_rise = !scl_q && scl_i;
  wire logic stall_w = (ph_r == 2'h2) && !scl_i; // a slave stretching the clock holds us here
  wire logic snd_w = adr_r || !m_rd_r;
  wire logic waiting = st_r == i2cmx_pkg::S_WAIT;

  // status read: waiting, clock held low, busy, engine active
  wire logic [31:0] stat_w = {28'h0000000, waiting, clk_low_r, busy_r, st_r != i2cmx_pkg::S_IDLE};
  wire logic [31:0] rd_mux =
    hit(ad_r, `I2CMX_OFF_CTRL) ? {26'h0000000, stop_req_r, start_req_r, ctrl_r} :
    hit(ad_r, `I2CMX_OFF_DIV) ? {16'h0000, div_r} :
    hit(ad_r, `I2CMX_OFF_OWN) ? {25'h0000000, own_r} :
    hit(ad_r, `I2CMX_OFF_TGT) ? {25'h0000000, tgt_r} :
    hit(ad_r, `I2CMX_OFF_STAT) ? stat_w :
    hit(ad_r, `I2CMX_OFF_TRANSMIT_BUFFER) ? {24'h000000, transmit_buffer_r} :
    hit(ad_r, `I2CMX_OFF_RXBUF) ? {24'h000000, rxbuf_r} :
    hit(ad_r, `I2CMX_OFF_IFG) ? {26'h0000000, flags_w} :
    hit(ad_r, `I2CMX_OFF_IE) ? {26'h0000000, mask_r} : 32'h00000000;

  // events: bus start/stop from the monitor, the rest from the engines
  wire logic [`I2CMX_NEV-1:0] ev_w = {stop_det, start_det, ev_r[3:2], ev_r[1] | sl_load_r, ev_r[0]};
  wire logic [`I2CMX_NEV-1:0] w1c_w = wr_ifg ? hwdata[`I2CMX_NEV-1:0] : 6'h00;
  wire logic [`I2CMX_NEV-1:0] hwclr_w = {4'h0, rd_rxbuf, wr_transmit_buffer};

  i2cmx_clkdiv u_div (
    .clk(hclk),
    .rst_n(hresetn),
    .en(en_w),
    .div(div_r),
    .tick(tick)
  );

  i2cmx_irq u_irq (
    .clk(hclk),
    .rst_n(hresetn),
    .set(ev_w),
    .w1c(w1c_w),
    .hwclr(hwclr_w),
    .mask(mask_r),
    .flags(flags_w),
    .irq(irq_w)
  );

  // reads take one wait state so that hrdata comes straight from a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ad_r <= 8'h00;
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      hreadyout_r <= 1'b1;
      hrdata_r <= 32'h00000000;
    end else begin
      wr_r <= addr_ph && hwrite;
      rd_r <= addr_ph && !hwrite;
      hreadyout_r <= !(addr_ph && !hwrite);
      if (addr_ph) begin
        ad_r <= haddr[7:0];
      end
      if (rd_r) begin
        hrdata_r <= rd_mux;
      end
    end
  end

  // plain configuration registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= `I2CMX_CTRL_RST;
      div_r <= 16'(`I2CMX_DIV_RST);
      own_r <= `I2CMX_OWN_RST;
      tgt_r <= `I2CMX_TGT_RST;
      mask_r <= `I2CMX_IE_RST;
    end else if (wr_r) begin
      if (hit(ad_r, `I2CMX_OFF_CTRL)) ctrl_r <= hwdata[3:0];
      if (hit(ad_r, `I2CMX_OFF_DIV)) div_r <= hwdata[15:0];
      if (hit(ad_r, `I2CMX_OFF_OWN)) own_r <= hwdata[6:0];
      if (hit(ad_r, `I2CMX_OFF_TGT)) tgt_r <= hwdata[6:0];
      if (hit(ad_r, `I2CMX_OFF_IE)) mask_r <= hwdata[`I2CMX_NEV-1:0];
    end
  end

  // bus monitor: busy between start and stop, live clock-low indicator
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      busy_r <= 1'b0;
      clk_low_r <= 1'b0;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
      clk_low_r <= !scl_i;
      if (start_det) busy_r <= 1'b1;
      else if (stop_det) busy_r <= 1'b0;
    end
  end

  // master engine; four bit-clock phases per bus bit, each start margin only one phase,
  // so above 50 kHz on the bus the start set-up and hold can come out short
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= i2cmx_pkg::S_IDLE;
      ph_r <= 2'h0;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      adr_r <= 1'b0;
      m_rd_r <= 1'b0;
      nk_r <= 1'b0;
      m_scl_dn_r <= 1'b0;
      m_sda_dn_r <= 1'b0;
      start_req_r <= 1'b0;
      stop_req_r <= 1'b0;
      transmit_buffer_r <= 8'h00;
      txfull_r <= 1'b0;
      rxbuf_r <= 8'h00;
      ev_r <= 4'h0;
    end else if (!en_w) begin
      st_r <= i2cmx_pkg::S_IDLE;
      ph_r <= 2'h0;
      m_scl_dn_r <= 1'b0;
      m_sda_dn_r <= 1'b0;
      start_req_r <= 1'b0;
      stop_req_r <= 1'b0;
      txfull_r <= 1'b0;
      ev_r <= 4'h0;
    end else begin
      ev_r <= 4'h0;
      if (sl_load_r) rxbuf_r <= sl_sh_r;
      // transmit flag follows foreign clock edges while parked
      if (waiting && mm_w && tr_w && scl_fall) ev_r[`I2CMX_F_TX] <= 1'b1;
      if (tick && !stall_w) begin
        case (st_r)
          i2cmx_pkg::S_IDLE: begin
            ph_r <= 2'h0;
            if (mst_w && start_req_r) begin
              st_r <= busy_r ? i2cmx_pkg::S_WAIT : i2cmx_pkg::S_START;
            end
          end
          i2cmx_pkg::S_WAIT: begin
            if (!busy_r) st_r <= i2cmx_pkg::S_START;
          end
          i2cmx_pkg::S_START: begin
            ph_r <= ph_r + 2'h1;
            case (ph_r)
              2'h0: m_sda_dn_r <= 1'b0;
              2'h1: m_scl_dn_r <= 1'b0;
              2'h2: m_sda_dn_r <= 1'b1;
              default: begin
                m_scl_dn_r <= 1'b1;
                sh_r <= {tgt_r, !tr_w};
                m_rd_r <= !tr_w;
                adr_r <= 1'b1;
                cnt_r <= 4'h0;
                st_r <= i2cmx_pkg::S_BITS;
                start_req_r <= 1'b0;
                if (tr_w) ev_r[`I2CMX_F_TX] <= 1'b1;
              end
            endcase
          end
          i2cmx_pkg::S_BITS: begin
            ph_r <= ph_r + 2'h1;
            case (ph_r)
              2'h0: m_sda_dn_r <= snd_w && !sh_r[7];
              2'h1: m_scl_dn_r <= 1'b0;
              2'h2: begin
                sh_r <= {sh_r[6:0], sda_i};
                if (snd_w && sh_r[7] && !sda_i) begin // another master pulled a one low
                  st_r <= i2cmx_pkg::S_IDLE;
                  ph_r <= 2'h0;
                  ev_r[`I2CMX_F_ARB] <= 1'b1;
                end
              end
              default: begin
                m_scl_dn_r <= 1'b1;
                cnt_r <= cnt_r + 4'h1;
                if (cnt_r == 4'h7) st_r <= i2cmx_pkg::S_ACK;
              end
            endcase
          end
          i2cmx_pkg::S_ACK: begin
            ph_r <= ph_r + 2'h1;
            case (ph_r)
              2'h0: begin
                if (!snd_w && flags_w[`I2CMX_F_RX]) begin
                  ph_r <= 2'h0; // old byte unread: hold the clock low
                end else if (!snd_w) begin
                  rxbuf_r <= sh_r;
                  ev_r[`I2CMX_F_RX] <= 1'b1;
                  m_sda_dn_r <= !stop_req_r; // last byte is not acknowledged
                end else begin
                  m_sda_dn_r <= 1'b0;
                end
              end
              2'h1: m_scl_dn_r <= 1'b0;
              2'h2: nk_r <= sda_i;
              default: begin
                m_scl_dn_r <= 1'b1;
                if (snd_w && nk_r) begin
                  ev_r[`I2CMX_F_NACK] <= 1'b1;
                  st_r <= i2cmx_pkg::S_STOP;
                end else if (stop_req_r) begin
                  st_r <= i2cmx_pkg::S_STOP;
                end else if (start_req_r) begin
                  st_r <= i2cmx_pkg::S_START;
                end else if (m_rd_r) begin
                  adr_r <= 1'b0;
                  cnt_r <= 4'h0;
                  st_r <= i2cmx_pkg::S_BITS;
                end else if (txfull_r) begin
                  adr_r <= 1'b0;
                  sh_r <= transmit_buffer_r;
                  txfull_r <= 1'b0;
                  cnt_r <= 4'h0;
                  ev_r[`I2CMX_F_TX] <= 1'b1;
                  st_r <= i2cmx_pkg::S_BITS;
                end else begin
                  ph_r <= 2'h3; // nothing to send yet: stretch the clock
                end
              end
            endcase
          end
          i2cmx_pkg::S_STOP: begin
            ph_r <= ph_r + 2'h1;
            case (ph_r)
              2'h0: m_sda_dn_r <= 1'b1;
              2'h1: m_scl_dn_r <= 1'b0;
              2'h2: m_sda_dn_r <= 1'b0;
              default: begin
                stop_req_r <= 1'b0;
                st_r <= i2cmx_pkg::S_IDLE;
              end
            endcase
          end
          default: st_r <= i2cmx_pkg::S_IDLE;
        endcase
      end
      // software requests last, so a set in the same cycle beats the engine's clear
      if (wr_stt) start_req_r <= 1'b1;
      if (wr_ctrl && hwdata[`I2CMX_B_STP]) stop_req_r <= 1'b1;
      if (wr_transmit_buffer && !waiting) begin
        transmit_buffer_r <= hwdata[7:0];
        txfull_r <= 1'b1;
      end
    end
  end

  // slave receiver; no clock stretching, so an unread byte gets a nack instead
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sl_on_r <= 1'b0;
      sl_adr_r <= 1'b0;
      sl_cnt_r <= 4'h0;
      sl_sh_r <= 8'h00;
      sl_ack_r <= 1'b0;
      sl_load_r <= 1'b0;
    end else if (!en_w || mst_w || stop_det) begin
      sl_on_r <= 1'b0;
      sl_ack_r <= 1'b0;
      sl_cnt_r <= 4'h0;
      sl_load_r <= 1'b0;
    end else if (start_det) begin
      sl_on_r <= 1'b1;
      sl_adr_r <= 1'b1;
      sl_cnt_r <= 4'h0;
      sl_ack_r <= 1'b0;
      sl_load_r <= 1'b0;
    end else begin
      sl_load_r <= 1'b0;
      if (sl_on_r && scl_rise && sl_cnt_r < 4'h8) begin
        sl_sh_r <= {sl_sh_r[6:0], sda_i};
        sl_cnt_r <= sl_cnt_r + 4'h1;
      end
      if (sl_on_r && scl_fall && sl_cnt_r == 4'h8) begin
        sl_cnt_r <= 4'h9;
        if (sl_adr_r) begin
          sl_ack_r <= (sl_sh_r[7:1] == own_r) && !sl_sh_r[0];
          sl_on_r <= (sl_sh_r[7:1] == own_r) && !sl_sh_r[0];
        end else begin
          sl_ack_r <= !flags_w[`I2CMX_F_RX];
          sl_load_r <= !flags_w[`I2CMX_F_RX];
        end
      end
      if (sl_on_r && scl_fall && sl_cnt_r == 4'h9) begin
        sl_ack_r <= 1'b0;
        sl_adr_r <= 1'b0;
        sl_cnt_r <= 4'h0;
      end
    end
  end

  // pin drivers: open drain, the enable pulls the line low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
      drv_lvl_r <= 1'b0;
    end else begin
      scl_oe_r <= m_scl_dn_r;
      sda_oe_r <= m_sda_dn_r | sl_ack_r;
      drv_lvl_r <= 1'b0;
    end
  end

  assign hrdata = hrdata_r;
  assign hreadyout = hreadyout_r;
  assign hresp = drv_lvl_r;
  assign irq = irq_w;
  assign scl_o = drv_lvl_r;
  assign sda_o = drv_lvl_r;
  assign scl_oe = scl_oe_r;
  assign sda_oe = sda_oe_r;

  AST_CLK_LOW: assert property (@(posedge hclk) disable iff (!hresetn)
    (!scl_i [*2]) |-> clk_low_r)
    else $error("clock-low indicator not set while clock is low");

  AST_WAIT_ENTRY: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_r == i2cmx_pkg::S_IDLE && en_w && mst_w && mm_w && tr_w && start_req_r && busy_r && tick)
    |=> st_r == i2cmx_pkg::S_WAIT)
    else $error("busy bus did not park the start in the wait state");

  AST_WAIT_QUIET: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_r == i2cmx_pkg::S_WAIT) ##1 (st_r == i2cmx_pkg::S_WAIT) |=> !scl_oe && !sda_oe)
    else $error("lines driven while waiting for the bus");

  AST_TX_DISCARD: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_r == i2cmx_pkg::S_WAIT && wr_transmit_buffer && !txfull_r) |=> !txfull_r)
    else $error("transmit buffer write accepted while waiting");

  AST_TX_TOGGLE: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_r == i2cmx_pkg::S_WAIT && en_w && mm_w && tr_w && scl_fall) |-> ##2 flags_w[`I2CMX_F_TX])
    else $error("transmit flag did not follow foreign clock edge");

  AST_START_CLR: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_r == i2cmx_pkg::S_START && ph_r == 2'h3 && tick && en_w && !wr_stt)
    |=> !start_req_r && st_r == i2cmx_pkg::S_BITS)
    else $error("start request not cleared at address phase");

  AST_START_SHAPE: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_r == i2cmx_pkg::S_START && ph_r == 2'h3) |-> m_sda_dn_r && !m_scl_dn_r)
    else $error("start not formed with data low under high clock");

  AST_AHB_RD: assert property (@(posedge hclk) disable iff (!hresetn)
    (hsel && hready && htrans[1] && !hwrite) |=> !hreadyout ##1 hreadyout)
    else $error("read did not complete after one wait state");

endmodule : i2cmx_top
`default_nettype wire

// [pkg/i2cmx_cfg.svh]
`ifndef I2CMX_CFG_SVH
`define I2CMX_CFG_SVH

// clocking
`define I2CMX_CLK_HZ 40000000
`define I2CMX_SCL_MAX_HZ 50000
`define I2CMX_PHASES 4
`define I2CMX_DIV_RST (`I2CMX_CLK_HZ / (`I2CMX_PHASES * `I2CMX_SCL_MAX_HZ))

// register byte offsets
`define I2CMX_OFF_CTRL 8'h00
`define I2CMX_OFF_DIV 8'h04
`define I2CMX_OFF_OWN 8'h08
`define I2CMX_OFF_TGT 8'h0C
`define I2CMX_OFF_STAT 8'h10
`define I2CMX_OFF_TRANSMIT_BUFFER 8'h14
`define I2CMX_OFF_RXBUF 8'h18
`define I2CMX_OFF_IFG 8'h1C
`define I2CMX_OFF_IE 8'h20

// control bits
`define I2CMX_B_EN 0
`define I2CMX_B_MST 1
`define I2CMX_B_MM 2
`define I2CMX_B_TR 3
`define I2CMX_B_STT 4
`define I2CMX_B_STP 5

// event and flag bits
`define I2CMX_NEV 6
`define I2CMX_F_TX 0
`define I2CMX_F_RX 1
`define I2CMX_F_NACK 2
`define I2CMX_F_ARB 3
`define I2CMX_F_STT 4
`define I2CMX_F_STP 5

// reset values
`define I2CMX_CTRL_RST 4'h0
`define I2CMX_OWN_RST 7'h00
`define I2CMX_TGT_RST 7'h00
`define I2CMX_IE_RST 6'h00

`endif

// [pkg/i2cmx_pkg.sv]
package i2cmx_pkg;

  // master engine states
  typedef enum logic [2:0] {
    S_IDLE,
    S_WAIT,
    S_START,
    S_BITS,
    S_ACK,
    S_STOP
  } i2cmx_state_e;

  typedef logic [7:0] i2cmx_byte_t;

endpackage : i2cmx_pkg

// [design/i2cmx_clkdiv.sv]
`timescale 1ns/1ps
`default_nettype none
module i2cmx_clkdiv (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic en,
  input wire logic [15:0] div,
  output logic tick
);

  logic [15:0] cnt_r;

  // one tick every div+1 clocks; held off while the unit is in software reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 16'h0000;
      tick <= 1'b0;
    end else if (!en) begin
      cnt_r <= 16'h0000;
      tick <= 1'b0;
    end else if (cnt_r >= div) begin
      cnt_r <= 16'h0000;
      tick <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 16'h0001;
      tick <= 1'b0;
    end
  end

endmodule : i2cmx_clkdiv
`default_nettype wire

// [design/i2cmx_irq.sv]
`timescale 1ns/1ps
`default_nettype none
`include "i2cmx_cfg.svh"
module i2cmx_irq (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [`I2CMX_NEV-1:0] set,
  input wire logic [`I2CMX_NEV-1:0] w1c,
  input wire logic [`I2CMX_NEV-1:0] hwclr,
  input wire logic [`I2CMX_NEV-1:0] mask,
  output logic [`I2CMX_NEV-1:0] flags,
  output logic irq
);

  logic [`I2CMX_NEV-1:0] flags_nxt;

  // set wins over any clear landing in the same cycle
  assign flags_nxt = (flags & ~(w1c | hwclr)) | set;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags <= {`I2CMX_NEV{1'b0}};
      irq <= 1'b0;
    end else begin
      flags <= flags_nxt;
      irq <= |(flags_nxt & mask);
    end
  end

  AST_IRQ_LEVEL: assert property (@(posedge clk) disable iff (!rst_n)
    $stable(mask) |-> (irq == |(flags & mask)))
    else $error("interrupt level does not match unmasked flags");

endmodule : i2cmx_irq
`default_nettype wire

// [sim/i2cmx_bus_model.sv]
`timescale 1ns/1ps
`default_nettype none
// bus peer: a slave at ADDR, plus a foreign master that can occupy the bus
module i2cmx_bus_model #(
  parameter logic [6:0] ADDR = 7'h55
) (
  input wire logic scl,
  input wire logic sda,
  output logic scl_oe,
  output logic sda_oe
);
  logic [7:0] sh;
  logic [7:0] txb;
  logic first;
  logic acked;
  logic sending;
  int nbit;
  logic [7:0] tx_q[$];
  logic [7:0] got[$];

  // lines released at power-up; open-drain pull-ups give them a high level
  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
    first = 1'b0;
    sending = 1'b0;
    txb = 8'hFF;
    nbit = 0;
  end

  // any start condition restarts the byte framing
  always @(negedge sda) begin
    if (scl === 1'b1) begin
      nbit = 0;
      first = 1'b1;
      sending = 1'b0;
    end
  end

  // sample on the rising clock; a high level in the ack slot ends a read
  always @(posedge scl) begin
    if (nbit < 8) sh = {sh[6:0], sda};
    if (nbit == 8 && !first && sda === 1'b1) sending = 1'b0;
    nbit = nbit + 1;
  end

  // data and ack only change while the clock is low
  always @(negedge scl) begin
    if (nbit == 8) begin
      if (first || !sending) got.push_back(sh);
      if (first) begin
        acked = (sh[7:1] == ADDR);
        sending = acked & sh[0];
      end
      sda_oe = first ? acked : !sending;
      first = 1'b0;
    end else if (nbit == 9) begin
      nbit = 0;
      if (sending && tx_q.size() > 0) txb = tx_q.pop_front();
      sda_oe = sending & !txb[7];
    end else if (sending && nbit < 8) begin
      sda_oe = !txb[7 - nbit];
    end
  end

  // foreign master takes the bus and parks the clock low
  // the small lead keeps every line change clear of the dut's sampling edge
  task automatic grab;
    #3 sda_oe = 1'b1;
    #1000 scl_oe = 1'b1;
  endtask : grab

  // foreign clock pulses, never a whole byte, so the slave side stays quiet
  task automatic pulses(input int n);
    #3;
    repeat (n) begin
      #1000 scl_oe = 1'b0;
      #1000 scl_oe = 1'b1;
    end
  endtask : pulses

  // stop: clock released first, then data rises while the clock is high
  task automatic free;
    #1003 scl_oe = 1'b0;
    #1000 sda_oe = 1'b0;
  endtask : free
endmodule : i2cmx_bus_model
`default_nettype wire

// [sim/i2cmx_top_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "i2cmx_cfg.svh"
module i2cmx_top_tb;
  localparam int DIV_T = 1;
  logic hclk;
  logic hresetn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic irq;
  logic scl_o, scl_oe, sda_o, sda_oe;
  logic m_scl_oe, m_sda_oe;
  logic [31:0] d;
  time t0;
  int n_fail;
  int tests_run;
  logic [7:0] offs [8] = '{`I2CMX_OFF_CTRL, `I2CMX_OFF_DIV, `I2CMX_OFF_OWN, `I2CMX_OFF_TGT,
                           `I2CMX_OFF_STAT, `I2CMX_OFF_IFG, `I2CMX_OFF_IE, 8'h24};

  // wired-and of both parties with pull-ups
  wire logic scl_w = ~((scl_oe & ~scl_o) | m_scl_oe);
  wire logic sda_w = ~((sda_oe & ~sda_o) | m_sda_oe);

  i2cmx_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .scl_i(scl_w), .scl_o(scl_o),
    .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe));

  i2cmx_bus_model #(.ADDR(7'h55)) bus (.scl(scl_w), .sda(sda_w), .scl_oe(m_scl_oe), .sda_oe(m_sda_oe));

  // 40 MHz clock
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  task automatic end_of_test;
    if (n_fail == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_bit(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask : chk_bit

  // hready is sampled at the edge itself, before that edge's updates land
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
  endtask : wait_rdy

  // one single word transfer; the idle edge in front keeps every change just after a rising edge
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rdat);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h000000, a};
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    rdat = hrdata;
    chk_bit(hresp, 1'b0);
  endtask : ahb

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] x;
    ahb(1'b1, a, v, x);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    ahb(1'b0, a, 32'h00000000, v);
  endtask : rd

  // bounded polling of one register bit; a stuck bit shows as a mismatch
  task automatic poll(input logic [7:0] a, input int b, input logic v);
    int n;
    n = 0;
    do begin
      rd(a, d);
      n++;
    end while (d[b] !== v && n < 2000);
    chk_bit(d[b], v);
  endtask : poll

  // irq is a flop fed alongside the flags and lags a mask write by one clock, so let it settle before looking
  task automatic chk_irq(input logic v);
    repeat (2) @(posedge hclk);
    @(negedge hclk);
    chk_bit(irq, v);
  endtask : chk_irq

  // main sequence
  initial begin
    n_fail = 0;
    tests_run = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h00000000;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    // status is read-only and the hole at 0x24 ignores writes
    wr(`I2CMX_OFF_STAT, 32'hFFFFFFFF);
    wr(8'h24, 32'hFFFFFFFF);
    for (int i = 0; i < 8; i++) begin
      rd(offs[i], d);
      chk(d, (i == 1) ? 32'h000000C8 : 32'h00000000);
    end
    wr(`I2CMX_OFF_DIV, 32'(DIV_T));
    wr(`I2CMX_OFF_TGT, 32'h00000055);
    wr(`I2CMX_OFF_CTRL, 32'h0000000F);
    // a foreign master holds the bus with the clock parked low
    bus.grab();
    rd(`I2CMX_OFF_STAT, d);
    chk(d & 32'h0000000E, 32'h00000006);
    wr(`I2CMX_OFF_CTRL, 32'h0000001F);
    rd(`I2CMX_OFF_STAT, d);
    chk(d & 32'h00000008, 32'h00000008);
    rd(`I2CMX_OFF_CTRL, d);
    chk(d & 32'h00000010, 32'h00000010);
    wr(`I2CMX_OFF_TRANSMIT_BUFFER, 32'h000000A5);
    wr(`I2CMX_OFF_IFG, 32'h0000003F);
    bus.pulses(3);
    rd(`I2CMX_OFF_IFG, d);
    chk(d & 32'h00000001, 32'h00000001);
    chk_irq(1'b0);
    wr(`I2CMX_OFF_IE, 32'h00000001);
    chk_irq(1'b1);
    wr(`I2CMX_OFF_IFG, 32'h00000001);
    chk_irq(1'b0);
    // bus released: the queued start goes out, the dropped byte must not
    bus.got.delete();
    bus.free();
    poll(`I2CMX_OFF_CTRL, 4, 1'b0);
    rd(`I2CMX_OFF_STAT, d);
    chk(d & 32'h00000008, 32'h00000000);
    poll(`I2CMX_OFF_IFG, 0, 1'b1);
    wr(`I2CMX_OFF_TRANSMIT_BUFFER, 32'h0000003C);
    // stop only once the byte sits in the shifter, or the engine stops after the address
    poll(`I2CMX_OFF_IFG, 0, 1'b1);
    wr(`I2CMX_OFF_CTRL, 32'h0000002F);
    poll(`I2CMX_OFF_STAT, 1, 1'b0);
    chk(32'(bus.got.size()), 32'h00000002);
    chk({24'h000000, bus.got[0]}, 32'h000000AA);
    chk({24'h000000, bus.got[1]}, 32'h0000003C);
    // master read: first byte read late behind the clock-low wait, last byte at once
    bus.tx_q.push_back(8'h96);
    bus.tx_q.push_back(8'h69);
    wr(`I2CMX_OFF_CTRL, 32'h00000013);
    poll(`I2CMX_OFF_IFG, 1, 1'b1);
    t0 = $time;
    do begin
      rd(`I2CMX_OFF_STAT, d);
      if (d[2] !== 1'b1) t0 = $time;
    end while ($time - t0 <= 3 * (DIV_T + 1) * 25);
    // stop goes in before the read frees the buffer, so the last byte is not acknowledged
    wr(`I2CMX_OFF_CTRL, 32'h00000023);
    rd(`I2CMX_OFF_RXBUF, d);
    chk(d, 32'h00000096);
    poll(`I2CMX_OFF_IFG, 1, 1'b1);
    rd(`I2CMX_OFF_RXBUF, d);
    chk(d, 32'h00000069);
    rd(`I2CMX_OFF_IFG, d);
    chk(d & 32'h00000002, 32'h00000000);
    poll(`I2CMX_OFF_STAT, 1, 1'b0);
    end_of_test();
  end

  // watchdog well beyond the expected bus time
  initial begin
    #2000000;
    n_fail++;
    end_of_test();
  end
endmodule : i2cmx_top_tb
`default_nettype wire
